// >>> cfl_pkg.sv
// Purpose: shared constants and types for the channel fault latch
// Assumes: 250 MHz core clock
// Notes:   one field layout serves condition, enable and latched registers
package cfl_pkg;

  // Bit positions within each 8-bit channel register
  localparam int BIT_VOLTAGE_REGULATING     = 0;
  localparam int BIT_POSITIVE_CURRENT_LIMIT = 1;
  localparam int BIT_NEGATIVE_CURRENT_LIMIT = 2;
  localparam int BIT_EXCESS_VOLTAGE_TRIP    = 3;
  localparam int BIT_THERMAL_TRIP           = 4;
  localparam int BIT_REGULATION_LOST        = 5;
  localparam int BIT_CURRENT_TRIP_FLAG      = 6;
  localparam int BIT_COUPLED_PARAMETER_FLAG = 7;

  localparam int REG_WIDTH = 8;

  // Bits hidden during holdoff
  localparam logic [7:0] HOLDOFF_HIDE_MASK = 8'h27;

  // Reset values
  localparam logic [7:0]  ENABLE_RESET  = 8'h00;
  localparam logic [7:0]  LATCHED_RESET = 8'h00;

  // Holdoff timing: 4 ms tick, 0..8000 ticks (32 s), default 5 ticks (20 ms)
  localparam int CLK_MHZ          = 250;
  localparam int HOLDOFF_STEP_US  = 4000;
  localparam int STEP_CYCLES      = HOLDOFF_STEP_US * CLK_MHZ;
  localparam int HOLDOFF_MAX_MS   = 32000;
  localparam int HOLDOFF_STEP_MS  = 4;
  localparam int HOLDOFF_MAX_STEP = HOLDOFF_MAX_MS / HOLDOFF_STEP_MS;
  localparam int HOLDOFF_DEF_MS   = 20;
  localparam logic [12:0] HOLDOFF_RESET = 13'(HOLDOFF_DEF_MS / HOLDOFF_STEP_MS);

  // One reprogramming command strobe group, per channel
  typedef struct packed {
    logic voltageSetpoint;
    logic currentSetpoint;
    logic excessVoltageClear;
    logic currentTripClear;
    logic outputOnOff;
    logic settingRecall;
  } cfl_cmd_t;

endpackage

// >>> cfl_holdoff_timer.sv
// Purpose: one channel's reprogramming holdoff counter
// Assumes: tick is a one-cycle enable every holdoff step
// Notes:   a restart reloads the count; zero duration gives no holdoff
`timescale 1ns/1ps
module cfl_holdoff_timer (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Control
  input  wire logic        tick,
  input  wire logic        restart,
  input  wire logic [12:0] duration,
  // Status
  output logic             active
);

  logic [12:0] remaining;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      remaining <= 13'h0000;
    end else if (restart) begin
      remaining <= duration;
    end else if (tick && remaining != 13'h0000) begin
      remaining <= remaining - 13'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      active <= 1'b0;
    end else if (restart) begin
      active <= (duration != 13'h0000);
    end else if (tick && remaining <= 13'h0001) begin
      active <= 1'b0;
    end
  end

endmodule

// >>> cfl_channel_fault_latch.sv
// Purpose: per-channel condition, enable and latched fault registers with holdoff
// Assumes: live conditions come from pins; commands and accesses are core_clk strobes
// Notes:   holdoff counts in 4 ms ticks from a shared divider
//
// What this block does
// - Every channel has its own condition, enable and latched registers.
// - Eight bits, bit 7 coupled parameter down to bit 0 voltage regulating.
// - Latched bit sets when condition rises while its enable bit is one.
// - Latched bits set only on a condition or enable change.
// - Newly enabled bit with condition already true sets latched bit.
// - Enable gates only the latch path; condition stays live.
// - Reading latched register returns contents and clears it at once.
// - During holdoff regulation bits hidden from latch and current trip.
// - Holdoff restarts on setpoint, clear, output or recall commands.
// - Holdoff duration programmable 0 to 32 s in 4 ms steps.
// - Holdoff duration defaults to 20 ms after reset.
// - Positive current limit with guard enabled trips the output.
`timescale 1ns/1ps
module cfl_channel_fault_latch #(
  parameter int CHANNELS    = 4,
  parameter int STEP_CYCLES = cfl_pkg::STEP_CYCLES
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // Live channel conditions from pins, bit 6 replaced internally by the trip state
  input  wire logic [CHANNELS*8-1:0] liveCondition,
  input  wire logic [CHANNELS-1:0]   currentTripGuard,
  // Reprogramming commands, one strobe group per channel
  input  cfl_pkg::cfl_cmd_t [CHANNELS-1:0] cmd,
  // Register access
  input  wire logic [CHANNELS-1:0]   enableWriteEntry,
  input  wire logic [7:0]            enableWriteData,
  input  wire logic [CHANNELS-1:0]   holdoffWrite,
  input  wire logic [12:0]           holdoffDurationSetting,
  input  wire logic [CHANNELS-1:0]   latchedRead,
  // Register contents
  output logic [CHANNELS*8-1:0]      channelCondition,
  output logic [CHANNELS*8-1:0]      channelFaultEnable,
  output logic [CHANNELS*8-1:0]      channelLatchedEvents,
  output logic [CHANNELS*8-1:0]      latchedReadData,
  // Protection
  output logic [CHANNELS-1:0]        currentTripFlag,
  output logic [CHANNELS-1:0]        holdoffActive
);

  localparam int DIV_W = $clog2(STEP_CYCLES);

  // Holdoff length helper, clamped to the 32 s ceiling
  function automatic logic [12:0] clamp_hold(input logic [12:0] v);
    if (v > 13'(cfl_pkg::HOLDOFF_MAX_STEP)) begin
      return 13'(cfl_pkg::HOLDOFF_MAX_STEP);
    end
    return v;
  endfunction

  // Shared 4 ms step divider
  logic [DIV_W-1:0] divCount;
  logic             stepTick;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      divCount <= '0;
      stepTick <= 1'b0;
    end else if (divCount == DIV_W'(STEP_CYCLES - 1)) begin
      divCount <= '0;
      stepTick <= 1'b1;
    end else begin
      divCount <= divCount + 1'b1;
      stepTick <= 1'b0;
    end
  end

  // Pin synchronisers: three stages, change taken when last two agree
  logic [CHANNELS*8-1:0] syncA;
  logic [CHANNELS*8-1:0] syncB;
  logic [CHANNELS*8-1:0] syncC;
  logic [CHANNELS*8-1:0] stableCond;
  logic [CHANNELS-1:0]   guardA;
  logic [CHANNELS-1:0]   guardB;
  logic [CHANNELS-1:0]   guardC;
  logic [CHANNELS-1:0]   stableGuard;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      syncA       <= '0;
      syncB       <= '0;
      syncC       <= '0;
      stableCond  <= '0;
      guardA      <= '0;
      guardB      <= '0;
      guardC      <= '0;
      stableGuard <= '0;
    end else begin
      syncA  <= liveCondition;
      syncB  <= syncA;
      syncC  <= syncB;
      guardA <= currentTripGuard;
      guardB <= guardA;
      guardC <= guardB;
      for (int i = 0; i < CHANNELS * 8; i++) begin
        if (syncB[i] == syncC[i]) begin
          stableCond[i] <= syncC[i];
        end
      end
      for (int j = 0; j < CHANNELS; j++) begin
        if (guardB[j] == guardC[j]) begin
          stableGuard[j] <= guardC[j];
        end
      end
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
      logic [12:0] holdDuration;
      logic        restart;
      logic        inHold;
      logic [7:0]  cond;
      logic [7:0]  visible;
      logic [7:0]  prevVisible;
      logic [7:0]  enable;
      logic [7:0]  prevEnable;
      logic [7:0]  latched;
      logic [7:0]  setBits;
      logic        tripped;

      assign restart = |cmd[ch];

      always_ff @(posedge core_clk) begin
        if (rst) begin
          holdDuration <= cfl_pkg::HOLDOFF_RESET;
        end else if (holdoffWrite[ch]) begin
          holdDuration <= clamp_hold(holdoffDurationSetting);
        end
      end

      cfl_holdoff_timer u_hold (
        .core_clk (core_clk),
        .rst      (rst),
        .tick     (stepTick),
        .restart  (restart),
        .duration (holdDuration),
        .active   (inHold)
      );

      // bit order; current trip bit from own trip state
      always_comb begin
        cond = stableCond[ch*8 +: 8];
        cond[cfl_pkg::BIT_CURRENT_TRIP_FLAG] = tripped;
      end

      assign visible = inHold ? (cond & ~cfl_pkg::HOLDOFF_HIDE_MASK) : cond;

      always_ff @(posedge core_clk) begin
        if (rst) begin
          tripped <= 1'b0;
        end else if (stableGuard[ch] && visible[cfl_pkg::BIT_POSITIVE_CURRENT_LIMIT]) begin
          // Set wins: a clear while the limit still shows keeps the output off
          tripped <= 1'b1;
        end else if (cmd[ch].currentTripClear) begin
          tripped <= 1'b0;
        end
      end

      always_ff @(posedge core_clk) begin
        if (rst) begin
          enable <= cfl_pkg::ENABLE_RESET;
        end else if (enableWriteEntry[ch]) begin
          enable <= enableWriteData;
        end
      end

      always_ff @(posedge core_clk) begin
        if (rst) begin
          prevVisible <= '0;
          prevEnable  <= cfl_pkg::ENABLE_RESET;
        end else begin
          prevVisible <= visible;
          prevEnable  <= enable;
        end
      end

      // edges only; enable gates latch path only
      assign setBits = enable & visible & (~prevVisible | ~prevEnable);

      // clear on read, new event wins
      always_ff @(posedge core_clk) begin
        if (rst) begin
          latched <= cfl_pkg::LATCHED_RESET;
        end else if (latchedRead[ch]) begin
          latched <= setBits;
        end else begin
          latched <= latched | setBits;
        end
      end

      always_ff @(posedge core_clk) begin
        if (rst) begin
          latchedReadData[ch*8 +: 8] <= '0;
        end else if (latchedRead[ch]) begin
          latchedReadData[ch*8 +: 8] <= latched;
        end
      end

      always_ff @(posedge core_clk) begin
        if (rst) begin
          channelCondition[ch*8 +: 8]     <= '0;
          channelFaultEnable[ch*8 +: 8]   <= cfl_pkg::ENABLE_RESET;
          channelLatchedEvents[ch*8 +: 8] <= cfl_pkg::LATCHED_RESET;
          currentTripFlag[ch]             <= 1'b0;
          holdoffActive[ch]               <= 1'b0;
        end else begin
          channelCondition[ch*8 +: 8]     <= cond;
          channelFaultEnable[ch*8 +: 8]   <= enable;
          channelLatchedEvents[ch*8 +: 8] <= latched;
          currentTripFlag[ch]             <= tripped;
          holdoffActive[ch]               <= inHold;
        end
      end
    end
  endgenerate

endmodule

// >>> cfl_checker_assertions.sv
// Purpose: port-level checks for the channel fault latch, channel 0
// Assumes: registered copies lag internal state by one cycle
// Notes:   bound into every instance of the latch
`timescale 1ns/1ps
module cfl_checker #(
  parameter int CHANNELS = 4
) (
  // Clock and reset
  input wire logic                      core_clk,
  input wire logic                      rst,
  // Stimulus side
  input wire logic [CHANNELS*8-1:0]     liveCondition,
  input cfl_pkg::cfl_cmd_t [CHANNELS-1:0] cmd,
  input wire logic [CHANNELS-1:0]       enableWriteEntry,
  input wire logic [7:0]                enableWriteData,
  input wire logic [CHANNELS-1:0]       latchedRead,
  input wire logic [CHANNELS-1:0]       holdoffWrite,
  input wire logic [12:0]               holdoffDurationSetting,
  // Register and protection outputs
  input wire logic [CHANNELS*8-1:0]     channelCondition,
  input wire logic [CHANNELS*8-1:0]     channelFaultEnable,
  input wire logic [CHANNELS*8-1:0]     channelLatchedEvents,
  input wire logic [CHANNELS*8-1:0]     latchedReadData,
  input wire logic [CHANNELS-1:0]       currentTripFlag,
  input wire logic [CHANNELS-1:0]       holdoffActive
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // Zero duration means a command starts no holdoff
  logic holdZero;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      holdZero <= 1'b0;
    end else if (holdoffWrite[0]) begin
      holdZero <= (holdoffDurationSetting == 13'h0000);
    end
  end

  reset_clears_a: assert property (disable iff (1'b0) rst ##1 rst |=>
    channelFaultEnable == '0 && channelLatchedEvents == '0 && holdoffActive == '0)
    else $error("reset left state behind");
  enable_write_a: assert property (enableWriteEntry[0] |->
    ##2 channelFaultEnable[7:0] == $past(enableWriteData, 2)) else $error("enable not written");
  latch_cause_a: assert property ($rose(channelLatchedEvents[0]) |->
    channelFaultEnable[0] || $past(channelFaultEnable[0])) else $error("latched without enable");
  read_data_a: assert property (latchedRead[0] |=>
    latchedReadData[7:0] == channelLatchedEvents[7:0]) else $error("read data wrong");
  holdoff_start_a: assert property (cmd[0] != '0 && !holdZero |-> ##[1:3] holdoffActive[0])
    else $error("holdoff did not start");
  holdoff_zero_a: assert property (cmd[0] != '0 && holdZero |-> ##2 !holdoffActive[0])
    else $error("zero holdoff still active");
  holdoff_cause_a: assert property ($rose(holdoffActive[0]) |->
    $past(cmd[0] != '0) || $past(cmd[0] != '0, 2) || $past(cmd[0] != '0, 3))
    else $error("holdoff without command");
  trip_clear_a: assert property (cmd[0].currentTripClear ##1 !channelCondition[1] |=>
    !currentTripFlag[0]) else $error("trip not cleared");
  cond_live_a: assert property ($stable(liveCondition[5:0]) [*6] |->
    channelCondition[5:0] == liveCondition[5:0]) else $error("condition not live");

  cover property (latchedRead[0] ##1 latchedReadData[7:0] != 8'h00);
  cover property ($fell(holdoffActive[0]));
  cover property ($rose(currentTripFlag[0]));
endmodule

bind cfl_channel_fault_latch cfl_checker #(.CHANNELS(CHANNELS)) chk (.core_clk, .rst,
  .liveCondition, .cmd, .enableWriteEntry, .enableWriteData, .latchedRead,
  .holdoffWrite, .holdoffDurationSetting,
  .channelCondition, .channelFaultEnable, .channelLatchedEvents, .latchedReadData,
  .currentTripFlag, .holdoffActive);

// >>> tb_top.sv
// Purpose: directed bench for the channel fault latch
// Assumes: two channels, holdoff step shortened to 4 cycles
// Notes:   inputs change on the falling edge
`timescale 1ns/1ps
module tb_top;
  localparam int CH = 2;
  logic                       core_clk = 1'b0;
  logic                       rst = 1'b1;
  logic [CH*8-1:0]            liveCondition = '0;
  logic [CH-1:0]              currentTripGuard = '0;
  cfl_pkg::cfl_cmd_t [CH-1:0] cmd = '0;
  logic [CH-1:0]              enableWriteEntry = '0;
  logic [CH-1:0]              holdoffWrite = '0;
  logic [CH-1:0]              latchedRead = '0;
  logic [7:0]                 enableWriteData = '0;
  logic [12:0]                holdoffDurationSetting = '0;
  logic [CH*8-1:0]            channelCondition, channelFaultEnable;
  logic [CH*8-1:0]            channelLatchedEvents, latchedReadData;
  logic [CH-1:0]              currentTripFlag, holdoffActive;
  int                         errors = 0;
  int                         check_count = 0;
  int                         n;

  always #2 core_clk = ~core_clk;

  cfl_channel_fault_latch #(.CHANNELS(CH), .STEP_CYCLES(4)) dut (.core_clk, .rst,
    .liveCondition, .currentTripGuard, .cmd, .enableWriteEntry, .enableWriteData,
    .holdoffWrite, .holdoffDurationSetting, .latchedRead, .channelCondition,
    .channelFaultEnable, .channelLatchedEvents, .latchedReadData, .currentTripFlag,
    .holdoffActive);

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask

  task automatic enable(input logic [7:0] v);
    enableWriteData = v;
    enableWriteEntry[0] = 1'b1;
    cyc(1);
    enableWriteEntry[0] = 1'b0;
    cyc(2);
  endtask

  task automatic read;
    latchedRead[0] = 1'b1;
    cyc(1);
    latchedRead[0] = 1'b0;
  endtask

  // Strobe command i on channel 0 and measure the holdoff in n
  task automatic hold(input int i);
    cmd[0] = cfl_pkg::cfl_cmd_t'(6'h20 >> i);
    cyc(1);
    cmd[0] = '0;
    cyc(3);
    check(8'(holdoffActive[0]), 8'h01);
    n = 4;
    while (holdoffActive[0] === 1'b1) begin
      cyc(1);
      n++;
      if (n > 300) begin
        errors++;
        summarize();
      end
    end
  endtask

  task automatic t_reset;
    check(channelFaultEnable[7:0] | channelLatchedEvents[7:0], 8'h00);
    check(8'(holdoffActive[0]), 8'h00);
    hold(0);
    check(8'(n >= 14 && n <= 28), 8'h01);
  endtask

  task automatic t_latch;
    enable(8'h09);
    check(channelFaultEnable[7:0], 8'h09);
    liveCondition[7:0] = 8'h19;
    cyc(8);
    check(channelCondition[7:0], 8'h19);
    check(channelLatchedEvents[7:0], 8'h09);
    check(channelLatchedEvents[15:8], 8'h00);
    read();
    check(latchedReadData[7:0], 8'h09);
    cyc(4);
    check(channelLatchedEvents[7:0], 8'h00);
    enable(8'h19);
    cyc(3);
    check(channelLatchedEvents[7:0], 8'h10);
    enable(8'h00);
    liveCondition[7:0] = 8'h00;
    cyc(6);
    liveCondition[7:0] = 8'h08;
    cyc(8);
    check(channelLatchedEvents[7:0], 8'h10);
  endtask

  task automatic t_holdoff;
    holdoffDurationSetting = 13'h4;
    holdoffWrite[0] = 1'b1;
    cyc(1);
    holdoffWrite[0] = 1'b0;
    for (int i = 1; i < 6; i++) begin
      hold(i);
      check(8'(n >= 12 && n <= 24), 8'h01);
    end
    enable(8'h02);
    read();
    currentTripGuard[0] = 1'b1;
    liveCondition[1] = 1'b1;
    cmd[0].voltageSetpoint = 1'b1;
    cyc(1);
    cmd[0] = '0;
    cyc(6);
    check(8'(currentTripFlag[0]) | channelLatchedEvents[7:0], 8'h00);
    cyc(20);
    check(8'(currentTripFlag[0]), 8'h01);
    liveCondition[1] = 1'b0;
    cyc(6);
    hold(3);
    check(8'(currentTripFlag[0]), 8'h00);
    holdoffDurationSetting = 13'h0;
    holdoffWrite[0] = 1'b1;
    cyc(1);
    holdoffWrite[0] = 1'b0;
    cmd[0].outputOnOff = 1'b1;
    cyc(1);
    cmd[0] = '0;
    cyc(3);
    check(8'(holdoffActive[0]), 8'h00);
  endtask

  initial begin
    cyc(2);
    rst = 1'b0;
    cyc(1);
    t_reset();
    t_latch();
    t_holdoff();
    summarize();
  end
endmodule
